/* src/ps_program_sequencer.sv */
// Purpose: Instruction sequencing: four phases, fetch/execute pipeline, program counter, program memory
// Assumes: Execute unit drives control requests while instr_valid is high and samples at phase_four
// Notes: Control requests are taken at the last edge of phase_four; stack storage lives outside
// What this block does
// - Four non-overlapping phases split each instruction cycle into four clock periods.
// - A word fetched in one cycle is executed in the next.
// - Any change of program counter costs one dummy cycle.
// - Program counter is ten bits, addressing 1024 words.
// - After each fetch the program counter advances by one.
// - Jumps, skips, low-byte writes, calls, reset, interrupts and returns load the counter.
// - A true skip discards the fetched word, inserts a dummy, continues at PC+2.
// - Low counter byte is readable and writable as a register.
// - Low-byte write replaces bits 7..0, keeps bits 9 and 8.
// - Jump and call load all ten bits from the instruction address field.
// - Return loads all ten bits from the saved stack entry.
// - Program memory holds 1024 words of 16 bits.
// - Reset clears the program counter to address 000.
// - Accepted timer interrupt vectors to address 004.
// - Accepted time base interrupt vectors to address 008.
`timescale 1ns/1ns
`default_nettype none
module ps_program_sequencer
	import ps_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Phase clocks
	output logic phase_one,
	output logic phase_two,
	output logic phase_three,
	output logic phase_four,
	// Pipeline toward the execute unit
	output logic [ps_pkg::PS_WORD_W-1:0] instr_word,
	output logic instr_valid,
	output logic [ps_pkg::PS_PC_W-1:0] fetch_addr,
	output logic [7:0] pc_low_byte,
	input wire logic skip_taken,
	input wire logic jump_req,
	input wire logic ret_req,
	input wire logic [ps_pkg::PS_PC_W-1:0] stack_value,
	input wire logic pc_low_wr,
	input wire logic [7:0] pc_low_wdata,
	// Interrupts, already qualified by enable and stack room
	input wire logic timer_int_req,
	input wire logic timebase_int_req,
	output logic timer_int_ack,
	output logic timebase_int_ack
);
	import ps_pkg::*;

	logic [PS_WORD_W-1:0] rom [0:PS_ROM_DEPTH-1];
	ps_phase_e phase;
	ps_phase_e next_phase;
	logic [PS_PC_W-1:0] pc;
	logic [PS_PC_W-1:0] next_pc;
	logic run;
	logic [PS_PC_W-1:0] rom_addr;
	logic [7:0] jmp_byte;
	logic jmp_pend;
	logic dp_wr;
	logic [PS_IDX_W-1:0] dp_idx;

	// Bus decode
	wire addr_ok = hsel & hready & (htrans == PS_HTRANS_NONSEQ);
	wire [PS_IDX_W-1:0] ap_idx = haddr[7:2];
	wire wr_ctrl = dp_wr & (dp_idx == PS_CTRL_IDX);
	wire wr_rom_addr = dp_wr & (dp_idx == PS_ROM_ADDR_IDX);
	wire wr_rom_data = dp_wr & (dp_idx == PS_ROM_DATA_IDX);
	wire wr_pcl = dp_wr & (dp_idx == PS_PC_LOW_BYTE_REG_IDX);

	// Sequencing decode
	wire step = run & (phase == PS_PH_FOUR);
	wire do_ret = instr_valid & ret_req;
	wire do_jump = instr_valid & jump_req;
	wire do_pcl = instr_valid & pc_low_wr;
	wire do_skip = instr_valid & skip_taken;
	wire instr_xfer = do_ret | do_jump | do_pcl | do_skip;
	// Bus short jump waits behind any transfer the executing word makes
	wire do_bus_pcl = jmp_pend & ~instr_xfer;
	wire do_tmr = timer_int_req & ~instr_xfer & ~jmp_pend;
	wire do_tb = timebase_int_req & ~instr_xfer & ~jmp_pend & ~timer_int_req;
	wire xfer = instr_xfer | jmp_pend | timer_int_req | timebase_int_req;

	always_comb begin
		if (do_ret) begin
			next_pc = stack_value;
		end else if (do_jump) begin
			next_pc = instr_word[PS_PC_W-1:0];
		end else if (do_pcl) begin
			next_pc = {pc[9:8], pc_low_wdata};
		end else if (do_skip) begin
			// Counter still points at the discarded word; adding one passes it
			next_pc = pc + PS_PC_ONE;
		end else if (do_bus_pcl) begin
			next_pc = {pc[9:8], jmp_byte};
		end else if (do_tmr) begin
			next_pc = PS_TIMER_VECTOR;
		end else if (do_tb) begin
			next_pc = PS_TIMEBASE_VECTOR;
		end else begin
			next_pc = pc + PS_PC_ONE;
		end
	end

	always_comb begin
		unique case (phase)
			PS_PH_ONE: next_phase = PS_PH_TWO;
			PS_PH_TWO: next_phase = PS_PH_THREE;
			PS_PH_THREE: next_phase = PS_PH_FOUR;
			PS_PH_FOUR: next_phase = PS_PH_ONE;
			default: next_phase = PS_PH_ONE;
		endcase
	end

	// Phases run free so timing stays fixed even while halted
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase <= PS_PH_ONE;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pc <= PS_RESET_VECTOR;
			instr_valid <= 1'b0;
			instr_word <= '0;
		end else if (step) begin
			pc <= next_pc;
			instr_valid <= ~xfer;
			if (!xfer) begin
				instr_word <= rom[pc];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_int_ack <= 1'b0;
			timebase_int_ack <= 1'b0;
		end else begin
			timer_int_ack <= step & do_tmr;
			timebase_int_ack <= step & do_tb;
		end
	end

	// A new bus write in the taking cycle wins over the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			jmp_pend <= 1'b0;
			jmp_byte <= 8'h00;
		end else if (wr_pcl) begin
			jmp_pend <= 1'b1;
			jmp_byte <= hwdata[7:0];
		end else if (step & do_bus_pcl) begin
			jmp_pend <= 1'b0;
		end
	end

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dp_wr <= 1'b0;
			dp_idx <= '0;
		end else if (hready) begin
			dp_wr <= addr_ok & hwrite;
			dp_idx <= ap_idx;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			run <= PS_CTRL_RUN_RST;
			rom_addr <= '0;
		end else begin
			if (wr_ctrl) begin
				run <= hwdata[PS_CTRL_RUN_BIT];
			end
			if (wr_rom_addr) begin
				rom_addr <= hwdata[PS_PC_W-1:0];
			end else if (wr_rom_data) begin
				rom_addr <= rom_addr + PS_PC_ONE;
			end
		end
	end

	// Memory has no reset; loaded by software before run is set
	always_ff @(posedge clock) begin
		if (wr_rom_data) begin
			rom[rom_addr] <= hwdata[PS_WORD_W-1:0];
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (ap_idx)
			PS_CTRL_IDX: rd_mux[PS_CTRL_RUN_BIT] = run;
			PS_STATUS_IDX: begin
				rd_mux[PS_PC_W-1:0] = pc;
				rd_mux[PS_STATUS_VALID_BIT] = instr_valid;
				rd_mux[PS_STATUS_PHASE_LSB +: 4] = phase;
			end
			PS_ROM_ADDR_IDX: rd_mux[PS_PC_W-1:0] = rom_addr;
			PS_ROM_DATA_IDX: rd_mux[PS_WORD_W-1:0] = rom[rom_addr];
			PS_PC_LOW_BYTE_REG_IDX: rd_mux[7:0] = pc[7:0];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok & ~hwrite) begin
			hrdata <= rd_mux;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign phase_one = (phase == PS_PH_ONE);
	assign phase_two = (phase == PS_PH_TWO);
	assign phase_three = (phase == PS_PH_THREE);
	assign phase_four = (phase == PS_PH_FOUR);
	assign fetch_addr = pc;
	assign pc_low_byte = pc[7:0];

	// Checks
	sequence phase_walk_s;
		phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
	endsequence

	// A vector or a bus short jump may be taken on the dummy step itself
	sequence dummy_then_exec_s;
		!instr_valid ##4 (instr_valid || !$past(run) || timer_int_ack || timebase_int_ack || $past(jmp_pend));
	endsequence

	phase_rotate_a: assert property (@(posedge clock) disable iff (rst)
		phase_one |=> phase_walk_s)
		else $error("phase order broken");

	phase_single_a: assert property (@(posedge clock) disable iff (rst)
		$onehot({phase_one, phase_two, phase_three, phase_four}))
		else $error("phases overlap");

	fetch_exec_a: assert property (@(posedge clock) disable iff (rst)
		(step && !xfer) |=> (instr_valid && instr_word == $past(rom[pc])))
		else $error("fetched word not executed next");

	xfer_dummy_a: assert property (@(posedge clock) disable iff (rst)
		(step && instr_xfer && !rst) |=> dummy_then_exec_s)
		else $error("transfer without one dummy cycle");

	pc_increment_a: assert property (@(posedge clock) disable iff (rst)
		(step && !xfer) |=> pc == $past(pc) + PS_PC_ONE)
		else $error("counter did not advance");

	skip_target_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_skip && !do_ret && !do_jump && !do_pcl) |=> (pc == $past(pc) + PS_PC_ONE) && !instr_valid)
		else $error("skip target wrong");

	short_jump_page_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_pcl && !do_ret && !do_jump) |=> pc == {$past(pc[9:8]), $past(pc_low_wdata)})
		else $error("short jump left page");

	jump_target_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_jump && !do_ret) |=> pc == $past(instr_word[PS_PC_W-1:0]))
		else $error("jump target wrong");

	return_target_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_ret) |=> pc == $past(stack_value))
		else $error("return target wrong");

	reset_vector_a: assert property (@(posedge clock)
		$fell(rst) |-> pc == PS_RESET_VECTOR && !instr_valid)
		else $error("reset vector wrong");

	timer_vector_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_tmr) |=> pc == PS_TIMER_VECTOR && timer_int_ack && !instr_valid)
		else $error("timer vector wrong");

	timebase_vector_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_tb) |=> pc == PS_TIMEBASE_VECTOR && timebase_int_ack && !instr_valid)
		else $error("time base vector wrong");

	bus_short_jump_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_bus_pcl) |=> pc == {$past(pc[9:8]), $past(jmp_byte)})
		else $error("bus short jump left page");

	pcl_write_taken_a: assert property (@(posedge clock) disable iff (rst)
		wr_pcl |=> jmp_pend && jmp_byte == $past(hwdata[7:0]))
		else $error("low byte write not held");

	pcl_read_a: assert property (@(posedge clock) disable iff (rst)
		(addr_ok && !hwrite && ap_idx == PS_PC_LOW_BYTE_REG_IDX) |=> hrdata == {24'h000000, $past(pc[7:0])})
		else $error("low byte read wrong");

	word_stands_a: assert property (@(posedge clock) disable iff (rst)
		!phase_four |=> $stable(instr_valid) && $stable(instr_word))
		else $error("executing word changed mid cycle");

	pc_holds_a: assert property (@(posedge clock) disable iff (rst)
		!step |=> $stable(pc))
		else $error("counter moved between steps");

	xfer_flush_a: assert property (@(posedge clock) disable iff (rst)
		(step && xfer) |=> !instr_valid && $stable(instr_word))
		else $error("transfer did not flush");

	halt_no_int_a: assert property (@(posedge clock) disable iff (rst)
		!run |=> !timer_int_ack && !timebase_int_ack)
		else $error("vector taken while halted");

	acks_exclusive_a: assert property (@(posedge clock) disable iff (rst)
		!(timer_int_ack && timebase_int_ack))
		else $error("two vectors at once");

	timer_ack_pulse_a: assert property (@(posedge clock) disable iff (rst)
		timer_int_ack |=> !timer_int_ack)
		else $error("timer ack too long");

	timebase_ack_pulse_a: assert property (@(posedge clock) disable iff (rst)
		timebase_int_ack |=> !timebase_int_ack)
		else $error("time base ack too long");

	timer_priority_a: assert property (@(posedge clock) disable iff (rst)
		(step && do_tmr) |=> !timebase_int_ack)
		else $error("time base beat timer");
endmodule
`default_nettype wire

/* src/ps_pkg.sv */
// Purpose: Shared constants and types of the program sequencer
// Assumes: 32-bit AHB-Lite register bus, word registers at index*4
// Notes: Register indices are word indices, byte address is four times the index
package ps_pkg;
	localparam int PS_PC_W = 10;
	localparam int PS_WORD_W = 16;
	localparam int PS_ROM_DEPTH = 1024;
	localparam int PS_IDX_W = 6;
	// Register word indices
	localparam logic [5:0] PS_CTRL_IDX = 6'h00;
	localparam logic [5:0] PS_STATUS_IDX = 6'h01;
	localparam logic [5:0] PS_ROM_ADDR_IDX = 6'h02;
	localparam logic [5:0] PS_ROM_DATA_IDX = 6'h03;
	localparam logic [5:0] PS_PC_LOW_BYTE_REG_IDX = 6'h06;
	// Field positions
	localparam int PS_CTRL_RUN_BIT = 0;
	localparam int PS_STATUS_VALID_BIT = 16;
	localparam int PS_STATUS_PHASE_LSB = 20;
	// Reset values, vectors and other fixed constants
	localparam logic PS_CTRL_RUN_RST = 1'b0;
	localparam logic [9:0] PS_RESET_VECTOR = 10'h000;
	localparam logic [9:0] PS_TIMER_VECTOR = 10'h004;
	localparam logic [9:0] PS_TIMEBASE_VECTOR = 10'h008;
	localparam logic [9:0] PS_PC_ONE = 10'h001;
	localparam logic [1:0] PS_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [3:0] {
		PS_PH_ONE = 4'h1,
		PS_PH_TWO = 4'h2,
		PS_PH_THREE = 4'h4,
		PS_PH_FOUR = 4'h8
	} ps_phase_e;
endpackage

/* dv/ps_exec_model.sv */
// Purpose: Execute-unit stand-in that turns the executing word into sequencer requests
// Assumes: Opcode nibble 1 jump, 2 skip, 3 return, 4 low-byte write, anything else no transfer
// Notes: Case equality keeps unloaded program words from raising requests
`timescale 1ns/1ns
`default_nettype none
module ps_exec_model
	import ps_pkg::*;
#(
	parameter logic [9:0] RET_ADDR = 10'h3f0
)(
	input wire logic instr_valid,
	input wire logic [ps_pkg::PS_WORD_W-1:0] instr_word,
	output logic jump_req,
	output logic skip_taken,
	output logic ret_req,
	output logic pc_low_wr,
	output logic [7:0] pc_low_wdata,
	output logic [ps_pkg::PS_PC_W-1:0] stack_value
);
	import ps_pkg::*;
	wire logic [3:0] op = instr_word[15:12];
	// Levels held through the whole valid cycle, so the step edge always sees them
	assign jump_req = instr_valid && (op === 4'h1);
	assign skip_taken = instr_valid && (op === 4'h2);
	assign ret_req = instr_valid && (op === 4'h3);
	assign pc_low_wr = instr_valid && (op === 4'h4);
	assign pc_low_wdata = instr_word[7:0];
	// One fixed saved entry; stack depth is outside this block
	assign stack_value = RET_ADDR;
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the program sequencer
// Assumes: Zero-wait AHB-Lite slave, execute-unit model on the request ports
// Notes: Program is loaded through the memory window before run is set
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ps_pkg::*;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0, tmr = 0, tbi = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	wire logic hreadyout, hresp, iv, p1, p2, p3, p4, jreq, sk, rq, lw, tack, back;
	wire logic [31:0] hrdata;
	wire logic [15:0] iw;
	wire logic [9:0] fa, sv;
	wire logic [7:0] pl, lwd;
	int miscompares = 0, comparisons = 0, cyc = 0, dummies = 0;
	logic [9:0] ea;
	logic [15:0] ew;
	// Idle loop at 3f0, service routines return, 380 jumps to itself: no unloaded word is fetched
	localparam logic [25:0] PROG [13] = '{{10'h000, 16'h0000}, {10'h001, 16'h2000}, {10'h002, 16'h0aaa},
		{10'h003, 16'h1120}, {10'h120, 16'h4055}, {10'h155, 16'h3000}, {10'h3f0, 16'h0000},
		{10'h3f1, 16'h13f0}, {10'h004, 16'h0000}, {10'h005, 16'h3000}, {10'h008, 16'h0000}, {10'h009, 16'h3000},
		{10'h380, 16'h1380}};
	localparam logic [25:0] EXP [6] = '{{10'h000, 16'h0000}, {10'h001, 16'h2000}, {10'h003, 16'h1120},
		{10'h120, 16'h4055}, {10'h155, 16'h3000}, {10'h3f0, 16'h0000}};

	ps_program_sequencer u_ps_program_sequencer (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_one(p1), .phase_two(p2),
		.phase_three(p3), .phase_four(p4), .instr_word(iw), .instr_valid(iv), .fetch_addr(fa),
		.pc_low_byte(pl), .skip_taken(sk), .jump_req(jreq), .ret_req(rq), .stack_value(sv),
		.pc_low_wr(lw), .pc_low_wdata(lwd), .timer_int_req(tmr), .timebase_int_req(tbi),
		.timer_int_ack(tack), .timebase_int_ack(back));
	ps_exec_model u_ps_exec_model (.instr_valid(iv), .instr_word(iw), .jump_req(jreq), .skip_taken(sk),
		.ret_req(rq), .pc_low_wr(lw), .pc_low_wdata(lwd), .stack_value(sv));

	initial begin
		forever #5 clock = ~clock;
	end

	task automatic end_of_test;
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// Address phase held until hready, then data phase held until hready again
	task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clock);
		haddr <= {24'h0, idx, 2'b00};
		htrans <= PS_HTRANS_NONSEQ;
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// Next executed word; fetch address already points one past it
	task automatic next_word;
		int i;
		i = 0;
		do begin
			@(posedge clock);
			#1;
			if (p1 === 1'b1 && iv !== 1'b1)
				dummies++;
			i++;
		end while (!(p1 === 1'b1 && iv === 1'b1) && i < 200);
		ea = fa - 10'h001;
		ew = iw;
	endtask

	task automatic phases;
		logic [3:0] p;
		@(posedge clock);
		#1;
		p = {p4, p3, p2, p1};
		chk("phase_ones", 32'd1, $countones(p));
		repeat (8) begin
			@(posedge clock);
			#1;
			chk("phase", {28'h0, p[2:0], p[3]}, {28'h0, p4, p3, p2, p1});
			p = {p4, p3, p2, p1};
		end
	endtask

	task automatic run_program;
		foreach (PROG[k]) begin
			bus(1'b1, PS_ROM_ADDR_IDX, {22'h0, PROG[k][25:16]});
			bus(1'b1, PS_ROM_DATA_IDX, {16'h0, PROG[k][15:0]});
		end
		bus(1'b1, PS_CTRL_IDX, 32'h1);
		next_word;
		dummies = 0;
		chk("exec", EXP[0], {ea, ew});
		for (int k = 1; k < 6; k++) begin
			next_word;
			chk("exec", EXP[k], {ea, ew});
		end
		chk("dummies", 32'd4, dummies);
	endtask

	// One request at a time: a level still high would vector again on the dummy step
	task automatic interrupts;
		int c0;
		@(posedge clock);
		tmr <= 1'b1;
		for (int i = 0; i < 100 && tack !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		c0 = cyc;
		chk("timer_ack", 32'd1, {31'h0, tack});
		chk("timer_flush", 32'd0, {31'h0, iv});
		@(posedge clock);
		tmr <= 1'b0;
		next_word;
		chk("timer_vector", {22'h0, PS_TIMER_VECTOR}, {22'h0, ea});
		chk("int_dummy", 32'd4, cyc - c0);
		@(posedge clock);
		tbi <= 1'b1;
		for (int i = 0; i < 100 && back !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		c0 = cyc;
		chk("timebase_ack", 32'd1, {31'h0, back});
		chk("timebase_flush", 32'd0, {31'h0, iv});
		@(posedge clock);
		tbi <= 1'b0;
		next_word;
		chk("timebase_vector", {22'h0, PS_TIMEBASE_VECTOR}, {22'h0, ea});
		chk("int_dummy", 32'd4, cyc - c0);
	endtask

	// Write lands inside the 3f0 cycle, so the page kept is 3
	task automatic short_jump;
		for (int k = 0; k < 8 && ea !== 10'h3f0; k++)
			next_word;
		bus(1'b1, PS_PC_LOW_BYTE_REG_IDX, 32'h80);
		for (int k = 0; k < 4 && ea !== 10'h380; k++)
			next_word;
		chk("short_jump", 32'h380, {22'h0, ea});
		chk("pc_low_byte", 32'h81, {24'h0, pl});
		bus(1'b0, PS_PC_LOW_BYTE_REG_IDX, 32'h0);
		chk("pc_low_read", 32'h80, rd & 32'hffff_fffe);
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test;
		end
	end

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, PS_CTRL_IDX, 32'h0);
		chk("ctrl_reset", 32'h0, rd);
		bus(1'b0, PS_STATUS_IDX, 32'h0);
		chk("status_reset", 32'h0, rd & 32'h0001_03ff);
		bus(1'b0, 6'h0f, 32'h0);
		chk("unmapped", 32'h0, rd);
		phases;
		run_program;
		interrupts;
		short_jump;
		end_of_test;
	end
endmodule
`default_nettype wire
